// [inc/hss_pkg.sv]
// Constants, modes and states of the home seek sequencer
package hss_pkg;
  localparam int SPEED_W = 22;
  localparam int STEP_W = 23;
  localparam int POS_W = 32;
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_TWO_SNS = 2'h0;
  localparam logic [MODE_W-1:0] MODE_THREE_SNS = 2'h1;
  localparam logic [MODE_W-1:0] MODE_ONE_WAY = 2'h2;
  localparam logic DIR_NEG = 1'b0;
  localparam logic DIR_POS = 1'b1;
  localparam int SNS_N = 5;
  localparam int SNS_FWD = 0;
  localparam int SNS_REV = 1;
  localparam int SNS_ORG = 2;
  localparam int SNS_GAP = 3;
  localparam int SNS_ZPH = 4;
  localparam logic [SPEED_W-1:0] SPEED_RST = 22'h000000;
  localparam logic [STEP_W-1:0] STEP_RST = 23'h000000;
  localparam logic [POS_W-1:0] POS_RST = 32'h00000000;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SEEK,
    ST_LIM_ESC,
    ST_DECEL,
    ST_ORG_ESC,
    ST_OFFSET,
    ST_EXT,
    ST_STOP
  } hss_state_t;
endpackage

// [verilog/hss_step_counter.sv]
// Step down-counter for the final offset travel
`timescale 1ns/100ps
`default_nettype none
module hss_step_counter
  import hss_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [STEP_W-1:0] i_load_value,
  input wire logic i_step,
  output logic o_done
);
  logic [STEP_W-1:0] cnt_q, cnt_d;
  logic armed_q, armed_d;
  logic done_q, done_d;

  // Load, then count steps down to zero
  always_comb begin
    cnt_d = cnt_q;
    armed_d = armed_q;
    if (i_load) begin
      cnt_d = i_load_value;
      armed_d = 1'b1;
    end else if (armed_q && i_step && cnt_q != STEP_RST) begin
      cnt_d = cnt_q - 1'b1;
    end
    done_d = armed_d && (cnt_d == STEP_RST);
  end

  // Counter registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      cnt_q <= STEP_RST;
      armed_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;

  // Each step while armed, with no load, takes exactly one off a nonzero count
  a_count_step: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    (armed_q && i_step && !i_load && cnt_q != STEP_RST)
    |=> (cnt_q == STEP_W'($past(cnt_q) - 1'b1)) && !o_done || cnt_q == STEP_RST)
    else $error("step count did not decrement");
endmodule
`default_nettype wire

// [verilog/hss_home_seek_sequencer.sv]
// Return-to-home sequencer with macro operation entry
`timescale 1ns/100ps
`default_nettype none
module hss_home_seek_sequencer
  import hss_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_home_start,
  input wire logic [MODE_W-1:0] i_seek_mode,
  input wire logic i_start_dir,
  input wire logic i_gap_detect_en,
  input wire logic i_zero_phase_detect_en,
  input wire logic [SPEED_W-1:0] i_seek_operating_speed,
  input wire logic [SPEED_W-1:0] i_seek_starting_speed,
  input wire logic [SPEED_W-1:0] i_seek_final_speed,
  input wire logic [STEP_W-1:0] i_backward_steps,
  input wire logic [STEP_W-1:0] i_oneway_amount,
  input wire logic [POS_W-1:0] i_preset_pos,
  input wire logic i_fwd_limit_sensor_in,
  input wire logic i_rev_limit_sensor_in,
  input wire logic i_origin_sensor_in,
  input wire logic i_optical_gap_sensor_in,
  input wire logic i_encoder_zero_phase_out,
  input wire logic i_step_pulse,
  input wire logic i_motor_stopped,
  input wire logic i_macro_jog_req,
  input wire logic i_macro_cont_req,
  output logic o_move_en,
  output logic o_move_dir,
  output logic [SPEED_W-1:0] o_speed_cmd,
  output logic o_decel_stop,
  output logic o_busy,
  output logic o_home_done,
  output logic o_home_alarm,
  output logic o_preset_load,
  output logic [POS_W-1:0] o_machine_coord,
  output logic o_macro_active,
  output logic o_use_jog_params,
  output logic o_link_inhibit
);
  logic [SNS_N-1:0] sns_raw;
  logic sync1_q [SNS_N];
  logic sync2_q [SNS_N];
  logic prev_q [SNS_N];
  logic fwd, rev, org, org_rise, org_fall, gap_rise, zph_rise;
  logic limit_ahead, ext_en, ext_rise, cnt_done, cnt_load;
  logic [STEP_W-1:0] cnt_value;
  hss_state_t state_q, state_d;
  logic [MODE_W-1:0] mode_q, mode_d;
  logic dir_q, dir_d, move_q, move_d, decel_q, decel_d;
  logic [SPEED_W-1:0] speed_q, speed_d;
  logic busy_q, busy_d, alarm_q, alarm_d, done_q, done_d;
  logic preset_q, preset_d, outside_q, outside_d;
  logic gap_en_q, gap_en_d, zph_en_q, zph_en_d;
  logic macro_q, macro_d, jog_q, jog_d;
  logic [POS_W-1:0] coord_q, coord_d;

  assign sns_raw = {i_encoder_zero_phase_out, i_optical_gap_sensor_in,
                    i_origin_sensor_in, i_rev_limit_sensor_in,
                    i_fwd_limit_sensor_in};

  // Two-stage synchroniser plus edge history per sensor
  genvar g;
  for (g = 0; g < SNS_N; g++) begin : g_sync
    always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
        sync1_q[g] <= 1'b0;
        sync2_q[g] <= 1'b0;
        prev_q[g] <= 1'b0;
      end else begin
        sync1_q[g] <= sns_raw[g];
        sync2_q[g] <= sync1_q[g];
        prev_q[g] <= sync2_q[g];
      end
    end
  end

  // Sensor levels and edges
  assign fwd = sync2_q[SNS_FWD];
  assign rev = sync2_q[SNS_REV];
  assign org = sync2_q[SNS_ORG];
  assign org_rise = org && !prev_q[SNS_ORG];
  assign org_fall = !org && prev_q[SNS_ORG];
  assign gap_rise = sync2_q[SNS_GAP] && !prev_q[SNS_GAP];
  assign zph_rise = sync2_q[SNS_ZPH] && !prev_q[SNS_ZPH];
  assign limit_ahead = (dir_q == DIR_POS) ? fwd : rev;
  assign ext_en = gap_en_q || zph_en_q;
  assign ext_rise = (gap_en_q && gap_rise) || (zph_en_q && zph_rise);

  // Offset travel counter
  hss_step_counter u_step_counter (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(cnt_load),
    .i_load_value(cnt_value),
    .i_step(i_step_pulse),
    .o_done(cnt_done)
  );

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    dir_d = dir_q;
    move_d = move_q;
    decel_d = decel_q;
    speed_d = speed_q;
    busy_d = busy_q;
    alarm_d = alarm_q;
    done_d = 1'b0;
    preset_d = 1'b0;
    outside_d = outside_q;
    gap_en_d = gap_en_q;
    zph_en_d = zph_en_q;
    macro_d = macro_q;
    jog_d = jog_q;
    coord_d = coord_q;
    cnt_load = 1'b0;
    cnt_value = STEP_RST;
    case (state_q)
      ST_IDLE: begin
        if (macro_q) begin
          if (!i_macro_jog_req && !i_macro_cont_req) begin
            macro_d = 1'b0;
          end
        end else if (i_home_start && (i_seek_mode == MODE_TWO_SNS ||
            i_seek_mode == MODE_THREE_SNS ||
            i_seek_mode == MODE_ONE_WAY)) begin
          state_d = ST_SEEK;
          mode_d = i_seek_mode;
          dir_d = i_start_dir;
          move_d = 1'b1;
          busy_d = 1'b1;
          alarm_d = 1'b0;
          outside_d = !org;
          gap_en_d = i_gap_detect_en;
          zph_en_d = i_zero_phase_detect_en;
          if (i_seek_mode == MODE_TWO_SNS) begin
            speed_d = i_seek_starting_speed;
          end else begin
            speed_d = i_seek_operating_speed;
          end
        end else if (i_macro_jog_req || i_macro_cont_req) begin
          macro_d = 1'b1;
          jog_d = i_macro_jog_req;
        end
      end
      ST_SEEK: begin
        if (mode_q != MODE_ONE_WAY && limit_ahead) begin
          state_d = ST_LIM_ESC;
          dir_d = !dir_q;
          if (mode_q == MODE_TWO_SNS) begin
            speed_d = i_seek_final_speed;
          end
        end else if (org_rise && mode_q == MODE_THREE_SNS) begin
          if (ext_en) begin
            state_d = ST_EXT;
            speed_d = i_seek_final_speed;
          end else begin
            state_d = ST_STOP;
            move_d = 1'b0;
            decel_d = 1'b1;
          end
        end else if (org_rise && mode_q == MODE_ONE_WAY) begin
          state_d = ST_DECEL;
          move_d = 1'b0;
          decel_d = 1'b1;
        end
      end
      ST_LIM_ESC: begin
        if (!fwd && !rev) begin
          if (mode_q == MODE_THREE_SNS) begin
            state_d = ST_SEEK;
          end else begin
            state_d = ST_OFFSET;
            speed_d = i_seek_starting_speed;
            cnt_load = 1'b1;
            cnt_value = i_backward_steps;
          end
        end
      end
      ST_DECEL: begin
        if (org_fall && outside_q) begin
          state_d = ST_IDLE;
          decel_d = 1'b0;
          busy_d = 1'b0;
          alarm_d = 1'b1;
        end else if (i_motor_stopped) begin
          state_d = ST_ORG_ESC;
          decel_d = 1'b0;
          move_d = 1'b1;
          speed_d = i_seek_final_speed;
        end
      end
      ST_ORG_ESC: begin
        if (!org) begin
          state_d = ST_OFFSET;
          speed_d = i_seek_starting_speed;
          cnt_load = 1'b1;
          cnt_value = i_oneway_amount;
        end
      end
      ST_OFFSET: begin
        if (cnt_done) begin
          if (ext_en) begin
            state_d = ST_EXT;
            speed_d = i_seek_final_speed;
          end else begin
            state_d = ST_STOP;
            move_d = 1'b0;
            decel_d = 1'b1;
          end
        end
      end
      ST_EXT: begin
        if (ext_rise && (mode_q != MODE_THREE_SNS || org)) begin
          state_d = ST_STOP;
          move_d = 1'b0;
          decel_d = 1'b1;
        end
      end
      ST_STOP: begin
        if (i_motor_stopped) begin
          state_d = ST_IDLE;
          decel_d = 1'b0;
          busy_d = 1'b0;
          done_d = 1'b1;
          preset_d = 1'b1;
          coord_d = i_preset_pos;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      mode_q <= MODE_THREE_SNS;
      dir_q <= DIR_POS;
      move_q <= 1'b0;
      decel_q <= 1'b0;
      speed_q <= SPEED_RST;
      busy_q <= 1'b0;
      alarm_q <= 1'b0;
      done_q <= 1'b0;
      preset_q <= 1'b0;
      outside_q <= 1'b0;
      gap_en_q <= 1'b0;
      zph_en_q <= 1'b0;
      macro_q <= 1'b0;
      jog_q <= 1'b0;
      coord_q <= POS_RST;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      dir_q <= dir_d;
      move_q <= move_d;
      decel_q <= decel_d;
      speed_q <= speed_d;
      busy_q <= busy_d;
      alarm_q <= alarm_d;
      done_q <= done_d;
      preset_q <= preset_d;
      outside_q <= outside_d;
      gap_en_q <= gap_en_d;
      zph_en_q <= zph_en_d;
      macro_q <= macro_d;
      jog_q <= jog_d;
      coord_q <= coord_d;
    end
  end

  // Outputs straight from registers, except o_use_jog_params, which gates jog_q with macro_q
  assign o_move_en = move_q;
  assign o_move_dir = dir_q;
  assign o_speed_cmd = speed_q;
  assign o_decel_stop = decel_q;
  assign o_busy = busy_q;
  assign o_home_done = done_q;
  assign o_home_alarm = alarm_q;
  assign o_preset_load = preset_q;
  assign o_machine_coord = coord_q;
  assign o_macro_active = macro_q;
  assign o_use_jog_params = macro_q && jog_q;
  assign o_link_inhibit = macro_q;

  // Checks on the sequence
  a_limit_reverse: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_SEEK && mode_q == MODE_THREE_SNS && limit_ahead)
    |=> state_q == ST_LIM_ESC && o_move_dir != $past(o_move_dir))
    else $error("limit did not reverse travel");
  a_origin_halt: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_SEEK && mode_q == MODE_THREE_SNS && !limit_ahead &&
     org_rise && !ext_en) |=> o_decel_stop && !o_move_en)
    else $error("origin edge did not halt motor");
  a_ext_with_origin: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_EXT && mode_q == MODE_THREE_SNS && !org)
    |=> state_q == ST_EXT && o_busy)
    else $error("extension ended off origin");
  a_ext_complete: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_EXT && mode_q != MODE_THREE_SNS && ext_rise)
    |=> o_decel_stop ##0 o_busy)
    else $error("external signal did not end search");
  a_start_dir: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_IDLE && !macro_q && i_home_start &&
     i_seek_mode == MODE_TWO_SNS)
    |=> o_busy && o_move_en && o_move_dir == $past(i_start_dir) &&
        o_speed_cmd == $past(i_seek_starting_speed))
    else $error("two-sensor start wrong");
  a_two_escape: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_SEEK && mode_q == MODE_TWO_SNS && limit_ahead)
    |=> o_speed_cmd == $past(i_seek_final_speed) &&
        o_move_dir == !$past(o_move_dir))
    else $error("limit escape speed or direction wrong");
  a_oneway_decel: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_SEEK && mode_q == MODE_ONE_WAY && org_rise)
    |=> state_q == ST_DECEL && o_decel_stop)
    else $error("one-way did not decelerate");
  a_overshoot_alarm: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_DECEL && org_fall && outside_q)
    |=> o_home_alarm && !o_busy && !o_home_done)
    else $error("overshoot alarm missing");
  a_preset_done: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_STOP && i_motor_stopped)
    |=> o_preset_load && o_home_done && !o_busy &&
        o_machine_coord == $past(i_preset_pos) ##1 !o_preset_load)
    else $error("completion preset wrong");
  a_macro_entry: assert property (@(posedge i_sys_clk)
    disable iff (i_sys_rst)
    (state_q == ST_IDLE && !macro_q && !i_home_start && i_macro_jog_req)
    |=> o_link_inhibit && o_use_jog_params && !o_busy)
    else $error("macro entry wrong");
endmodule
`default_nettype wire

// [verification/hss_sensor_model.sv]
// Mechanism model: position, limit, origin, gap and zero-phase sensors
`timescale 1ns/100ps
`default_nettype none
module hss_sensor_model #(
  parameter logic signed [15:0] FWD_AT = 16'sh0028,
  parameter logic signed [15:0] REV_AT = 16'shffd8,
  parameter logic signed [15:0] ORG_LO = 16'sh000a,
  parameter logic signed [15:0] ORG_HI = 16'sh0014,
  parameter logic signed [15:0] GAP_AT = 16'sh000f
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_move_en,
  input wire logic i_move_dir,
  input wire logic i_decel_stop,
  input wire logic i_load,
  input wire logic signed [15:0] i_load_pos,
  input wire logic [7:0] i_decel_steps,
  output logic o_fwd,
  output logic o_rev,
  output logic o_org,
  output logic o_gap,
  output logic o_zph,
  output logic o_step,
  output logic o_stopped,
  output logic signed [15:0] o_pos
);
  logic [7:0] dec_q;
  logic [2:0] div_q;
  logic moving;
  // Motor overruns by the set number of steps after a stop request
  assign moving = i_move_en | (i_decel_stop & (dec_q != 8'h00));
  assign o_stopped = ~moving;
  // Sensor levels follow the shaft position
  assign o_fwd = o_pos >= FWD_AT;
  assign o_rev = o_pos <= REV_AT;
  assign o_org = (o_pos >= ORG_LO) && (o_pos <= ORG_HI);
  assign o_gap = o_pos == GAP_AT;
  assign o_zph = o_pos[2:0] == 3'h0;
  // One step every eight cycles while turning
  always_ff @(posedge i_sys_clk) begin
    o_step <= 1'b0;
    if (i_sys_rst) begin
      o_pos <= 16'sh0000;
      div_q <= 3'h0;
      dec_q <= 8'h00;
    end else if (i_load) begin
      o_pos <= i_load_pos;
    end else begin
      div_q <= moving ? div_q + 3'h1 : 3'h0;
      if (!i_decel_stop) begin
        dec_q <= i_decel_steps;
      end
      if (moving && div_q == 3'h7) begin
        o_step <= 1'b1;
        o_pos <= i_move_dir ? o_pos + 16'sh0001 : o_pos - 16'sh0001;
        if (i_decel_stop && !i_move_en) begin
          dec_q <= dec_q - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verification/hss_home_seek_sequencer_test.sv]
// Self-checking bench for the home seek sequencer
`timescale 1ns/100ps
`default_nettype none
module hss_home_seek_sequencer_test;
  import hss_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic hstart = 1'b0, start_dir = 1'b1, gap_en = 1'b0, zph_en = 1'b0;
  logic [MODE_W-1:0] mode = 2'h0;
  logic [SPEED_W-1:0] op_spd = 22'h0, st_spd = 22'h0, fin_spd = 22'h0;
  logic [STEP_W-1:0] bk_steps = 23'h0, ow_amt = 23'h0;
  logic [POS_W-1:0] preset = 32'h0;
  logic jog_req = 1'b0, cont_req = 1'b0, load = 1'b0;
  logic signed [15:0] load_pos = 16'sh0000;
  logic [7:0] dec_steps = 8'h00;
  logic fwd, rev, org, gap, zph, step, stopped;
  logic move_en, move_dir, decel, busy, done, alarm, pload, mact, ujog, linh;
  logic [SPEED_W-1:0] spd;
  logic [POS_W-1:0] coord;
  logic signed [15:0] pos, cap_pos;
  logic [SPEED_W-1:0] rev_spd;
  logic rev_seen = 1'b0, prev_busy = 1'b0, prev_dec = 1'b0, d;
  int fails = 0, n_checks = 0, cyc = 0, cnt = 0, i;

  always #5 i_sys_clk = ~i_sys_clk;

  hss_home_seek_sequencer hss_home_seek_sequencer_i (.i_sys_clk, .i_sys_rst,
    .i_home_start(hstart), .i_seek_mode(mode), .i_start_dir(start_dir),
    .i_gap_detect_en(gap_en), .i_zero_phase_detect_en(zph_en),
    .i_seek_operating_speed(op_spd), .i_seek_starting_speed(st_spd),
    .i_seek_final_speed(fin_spd), .i_backward_steps(bk_steps),
    .i_oneway_amount(ow_amt), .i_preset_pos(preset),
    .i_fwd_limit_sensor_in(fwd), .i_rev_limit_sensor_in(rev),
    .i_origin_sensor_in(org), .i_optical_gap_sensor_in(gap),
    .i_encoder_zero_phase_out(zph), .i_step_pulse(step),
    .i_motor_stopped(stopped), .i_macro_jog_req(jog_req),
    .i_macro_cont_req(cont_req), .o_move_en(move_en), .o_move_dir(move_dir),
    .o_speed_cmd(spd), .o_decel_stop(decel), .o_busy(busy),
    .o_home_done(done), .o_home_alarm(alarm), .o_preset_load(pload),
    .o_machine_coord(coord), .o_macro_active(mact),
    .o_use_jog_params(ujog), .o_link_inhibit(linh));

  hss_sensor_model hss_sensor_model_i (.i_sys_clk, .i_sys_rst,
    .i_move_en(move_en), .i_move_dir(move_dir), .i_decel_stop(decel),
    .i_load(load), .i_load_pos(load_pos), .i_decel_steps(dec_steps),
    .o_fwd(fwd), .o_rev(rev), .o_org(org), .o_gap(gap), .o_zph(zph),
    .o_step(step), .o_stopped(stopped), .o_pos(pos));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_checks = n_checks + 1;
    if (ok !== 1'b1) begin
      fails = fails + 1;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  // Expected speed of the first leg
  function automatic logic [SPEED_W-1:0] exp_spd(input logic [1:0] m);
    return (m === MODE_TWO_SNS) ? st_spd : op_spd;
  endfunction

  // Overrun past the origin window in one-way mode ends in an alarm
  function automatic logic exp_alarm(input logic [1:0] m, input logic [7:0] s);
    return (m === MODE_ONE_WAY) && (s > 8'h0b);
  endfunction

  // Monitor: timeout, reversal speed, last-leg steps, stop point
  always @(negedge i_sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      end_sim();
    end
    if (move_en === 1'b1 && spd !== st_spd) cnt = 0;
    else if (step === 1'b1 && busy === 1'b1 && spd === st_spd) cnt++;
    if (move_en === 1'b1 && move_dir !== start_dir && !rev_seen) begin
      rev_seen = 1'b1;
      rev_spd = spd;
    end
    if (decel === 1'b1 && !prev_dec) cap_pos = pos;
    if (prev_busy) chk(busy === 1'b1 || done === 1'b1 || alarm === 1'b1,
      "busy dropped early");
    prev_busy = busy;
    prev_dec = decel;
  end

  // One homing run from a given position
  task automatic run(input logic [1:0] m, input logic dr,
      input logic signed [15:0] p, input logic g, input logic z,
      input logic [7:0] ds);
    int t;
    @(negedge i_sys_clk);
    {load, load_pos, mode, start_dir, gap_en, zph_en} = {1'b1, p, m, dr, g, z};
    dec_steps = ds;
    st_spd = SPEED_W'($urandom_range(1, 1000));
    op_spd = st_spd + 22'h0003e8;
    fin_spd = st_spd + 22'h0007d0;
    bk_steps = STEP_W'($urandom_range(0, 12));
    ow_amt = STEP_W'($urandom_range(0, 12));
    preset = $urandom;
    @(negedge i_sys_clk);
    load = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    hstart = 1'b1;
    rev_seen = 1'b0;
    @(negedge i_sys_clk);
    hstart = 1'b0;
    @(negedge i_sys_clk);
    chk(busy === 1'b1 && alarm === 1'b0, "start");
    chk(move_en === 1'b1 && move_dir === dr, "start dir");
    chk(spd === exp_spd(m), "first speed");
    t = 0;
    while (done !== 1'b1 && alarm !== 1'b1 && t < 8000) begin
      @(negedge i_sys_clk);
      t++;
    end
    chk(t < 8000, "no end");
    chk(alarm === exp_alarm(m, ds), "alarm");
    if (alarm === 1'b0) begin
      chk(pload === 1'b1 && coord === preset, "preset");
      if (m === MODE_TWO_SNS) chk(rev_spd === fin_spd, "rev");
      if (m === MODE_THREE_SNS && rev_seen)
        chk(rev_spd === op_spd, "limit rev");
      if (m === MODE_ONE_WAY) chk(!rev_seen, "one-way reversed");
      if (g) chk(cap_pos >= 16'sh000f && cap_pos <= 16'sh0011, "gap");
      else if (z) chk(cap_pos[2:0] <= 3'h2, "zero phase");
      else if (m === MODE_TWO_SNS)
        chk(cnt == int'(bk_steps), "backward");
      else if (m === MODE_ONE_WAY) chk(cnt == int'(ow_amt), "amount");
      else chk(org === 1'b1, "halt off origin");
    end
    repeat (2) @(negedge i_sys_clk);
    chk(busy === 1'b0 && move_en === 1'b0 && done === 1'b0, "idle");
    chk(decel === 1'b0 && pload === 1'b0, "idle outputs");
  endtask

  initial begin
    void'($urandom(32'h9f56dc79));
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk(move_dir === DIR_POS && busy === 1'b0 && coord === POS_RST, "reset");
    chk(move_en === 1'b0 && decel === 1'b0 && mact === 1'b0, "reset outs");
    i_sys_rst = 1'b0;
    run(MODE_THREE_SNS, DIR_POS, 16'sh0019, 1'b0, 1'b0, 8'h02);
    run(MODE_THREE_SNS, DIR_NEG, 16'sh0000, 1'b1, 1'b0, 8'h02);
    run(MODE_TWO_SNS, DIR_NEG, 16'sh0000, 1'b0, 1'b1, 8'h02);
    run(MODE_ONE_WAY, DIR_POS, 16'shffec, 1'b0, 1'b1, 8'h02);
    run(MODE_ONE_WAY, DIR_POS, 16'shffec, 1'b0, 1'b0, 8'h14);
    run(MODE_TWO_SNS, DIR_POS, 16'shffe2, 1'b0, 1'b0, 8'h00);
    run(MODE_ONE_WAY, DIR_NEG, 16'sh001e, 1'b0, 1'b0, 8'h00);
    // Three-sensor extension: shaft knocked off the origin mid-search
    fork
      run(MODE_THREE_SNS, DIR_POS, 16'shffec, 1'b1, 1'b0, 8'h00);
      begin
        wait (busy === 1'b1 && move_en === 1'b1 && spd === fin_spd);
        @(negedge i_sys_clk);
        load_pos = 16'sh0019;
        load = 1'b1;
        @(negedge i_sys_clk);
        load = 1'b0;
        repeat (40) @(negedge i_sys_clk);
        chk(busy === 1'b1 && spd === fin_spd && org === 1'b0,
          "ext off origin");
        load_pos = 16'sh0005;
        load = 1'b1;
        @(negedge i_sys_clk);
        load = 1'b0;
      end
    join
    for (i = 0; i < 6; i++) begin
      d = 1'($urandom_range(0, 1));
      run(2'($urandom_range(0, 2)), d, d ? 16'shffe2 : 16'sh001e, 1'b0,
        1'b0, 8'h00);
    end
    // Unused mode code is refused
    mode = 2'h3;
    hstart = 1'b1;
    @(negedge i_sys_clk);
    hstart = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    chk(busy === 1'b0, "mode 3 started");
    // Macro entry and homing refused meanwhile
    mode = MODE_TWO_SNS;
    jog_req = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    chk(mact === 1'b1 && linh === 1'b1, "jog");
    chk(ujog === 1'b1, "jog params");
    hstart = 1'b1;
    @(negedge i_sys_clk);
    hstart = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk(busy === 1'b0, "homing in macro");
    jog_req = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk(mact === 1'b0 && linh === 1'b0, "macro end");
    cont_req = 1'b1;
    repeat (2) @(negedge i_sys_clk);
    chk(mact === 1'b1 && linh === 1'b1, "cont");
    chk(ujog === 1'b0, "cont params");
    cont_req = 1'b0;
    repeat (2) @(negedge i_sys_clk);
    chk(mact === 1'b0 && linh === 1'b0, "cont end");
    end_sim();
  end
endmodule
`default_nettype wire
